// ==== vto_pkg.sv ====
// Constants, register map and helpers for the tandem overhead termination block
// Operation
// - Source sends remote defect in frame 73 bit 8 within one multiframe of request.
// - Overhead bits 7 and 8 form a 76-frame multiframe lasting 38 ms.
// - Source always drives overhead bit 3 to one.
// - Source overhead bit 4 follows the adapted signal fail input.
// - Remote error input is sent in overhead bit 5 of the next frame.
// - Source sends outgoing defect in frame 74 bit 7 at first opportunity.
// - Outgoing error input is sent in overhead bit 6 of the next frame.
// - Source sends fifteen ones then a zero during frames 1 to 8.
// - Source sends the management trace identifier during frames 9 to 72.
// - Reserved multiframe bits of frames 73 to 76 are zero.
// - Source puts parity of each container frame into bits 1-2 next frame.
// - Source adjusts path parity in V5 whenever it rewrites the overhead byte.
// - V5 adjustment folds previous deltas of V5 and overhead into current V5.
// - Sink checks even bit-pair parity of previous frame, flags near errored block.
// - Sink recovers trace from frames 9 to 72, readable by management.
// - Sink trace handling supports only the first trace mode.
// - Sink extracts incoming AIS from overhead bit 4 every frame.
// - Sink extracts far errored block from bit 5, remote defect from frame 73.
// - Sink extracts outgoing error from bit 6, outgoing defect from frame 74.
// - Sink loses multiframe after two consecutive errored alignment patterns.
// - Sink regains multiframe on a single error-free alignment pattern.
package vto_pkg;
   localparam int VC_BYTES = 104;
   localparam int N2_POS = 52;
   localparam int POS_W = 7;
   localparam int MF_W = 7;
   localparam logic [MF_W-1:0] MF_LAST = 7'h4b;
   localparam int MF_TIME_MS = 38;
   localparam logic [MF_W-1:0] MF_FAS_END = 7'h07;
   localparam logic [MF_W-1:0] MF_TRACE_FIRST = 7'h08;
   localparam logic [MF_W-1:0] MF_TRACE_LAST = 7'h47;
   localparam logic [MF_W-1:0] MF_RDI = 7'h48;
   localparam logic [MF_W-1:0] MF_ODI = 7'h49;
   localparam logic [15:0] FAS_PATTERN = 16'hfffe;
   localparam int TRACE_BITS = 128;
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] REG_TX_TRACE0 = 6'h00;
   localparam logic [ADDR_W-1:0] REG_TX_TRACE1 = 6'h04;
   localparam logic [ADDR_W-1:0] REG_TX_TRACE2 = 6'h08;
   localparam logic [ADDR_W-1:0] REG_TX_TRACE3 = 6'h0c;
   localparam logic [ADDR_W-1:0] REG_ACC_TRACE0 = 6'h10;
   localparam logic [ADDR_W-1:0] REG_ACC_TRACE1 = 6'h14;
   localparam logic [ADDR_W-1:0] REG_ACC_TRACE2 = 6'h18;
   localparam logic [ADDR_W-1:0] REG_ACC_TRACE3 = 6'h1c;
   localparam logic [ADDR_W-1:0] REG_STATUS = 6'h20;
   localparam logic [TRACE_BITS-1:0] TX_TRACE_RESET = 128'h0;

   // Even bit-pair parity of one byte, bit 1 (msb) first
   function automatic logic [1:0] vto_fold(input logic [7:0] b);
      return {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
   endfunction
endpackage

// ==== vto_tandem_term.sv ====
// Tandem connection overhead source and sink with an Avalon-MM register slave
`timescale 1ns/100ps
module vto_tandem_term (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Link clock shared by both streams
   input wire logic link_clk_in,
   // Source stream in and out
   input wire logic [7:0] src_data_in,
   input wire logic src_fs_in,
   output logic [7:0] src_data_out,
   output logic src_fs_out,
   // Source indications from adjacent logic
   input wire logic adapted_signal_fail_in,
   input wire logic remote_defect_request_in,
   input wire logic remote_error_count_in,
   input wire logic outgoing_defect_request_in,
   input wire logic outgoing_error_count_in,
   // Sink stream in
   input wire logic [7:0] snk_data_in,
   input wire logic snk_fs_in,
   // Sink indications
   output logic near_errored_block_out,
   output logic far_errored_block_out,
   output logic outgoing_far_errored_block_out,
   output logic incoming_ais_out,
   output logic remote_defect_out,
   output logic outgoing_defect_out,
   output logic in_multiframe_out,
   // Avalon-MM slave
   input wire logic [vto_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);
   import vto_pkg::*;

   localparam logic [POS_W-1:0] LAST_POS = 7'(VC_BYTES - 1);
   localparam logic [POS_W-1:0] N2_AT = 7'(N2_POS);

   // Synchronisers: first stage read only by the second
   logic [2:0] lclk_sync;
   logic [8:0] src_s1, src_s2;
   logic [8:0] snk_s1, snk_s2;
   logic edge_seen;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lclk_sync <= 3'h0;
         src_s1 <= 9'h000;
         src_s2 <= 9'h000;
         snk_s1 <= 9'h000;
         snk_s2 <= 9'h000;
      end else begin
         lclk_sync <= {lclk_sync[1:0], link_clk_in};
         src_s1 <= {src_fs_in, src_data_in};
         src_s2 <= src_s1;
         snk_s1 <= {snk_fs_in, snk_data_in};
         snk_s2 <= snk_s1;
      end
   end

   // Data settle 62.5 ns around the link edge, so both paths line up
   assign edge_seen = lclk_sync[1] & ~lclk_sync[2];

   // ---------------- Source ----------------
   logic [POS_W-1:0] src_pos, next_src_pos;
   logic [MF_W-1:0] src_mf, next_src_mf;
   logic [1:0] src_acc, src_bip_prev, src_comp;
   logic [1:0] ei_acc, ei_frame;
   logic [TRACE_BITS-1:0] tx_trace;
   logic [1:0] src_mf_bits;
   logic [7:0] next_n2, next_src_byte;
   logic src_is_v5, src_is_n2;
   int k;

   always_comb begin
      k = int'(next_src_mf) - int'(MF_TRACE_FIRST);
      next_src_pos = (src_s2[8] || src_pos == LAST_POS) ? '0 : src_pos + 7'h01;
      src_is_v5 = (next_src_pos == '0);
      src_is_n2 = (next_src_pos == N2_AT);
      next_src_mf = (src_mf == MF_LAST) ? '0 : src_mf + 7'h01;
      if (next_src_mf < MF_FAS_END) begin
         src_mf_bits = 2'b11;
      end else if (next_src_mf == MF_FAS_END) begin
         src_mf_bits = 2'b10;
      end else if (next_src_mf <= MF_TRACE_LAST) begin
         src_mf_bits = tx_trace[TRACE_BITS - 1 - 2 * k -: 2];
      end else if (next_src_mf == MF_RDI) begin
         src_mf_bits = {1'b0, remote_defect_request_in};
      end else if (next_src_mf == MF_ODI) begin
         src_mf_bits = {outgoing_defect_request_in, 1'b0};
      end else begin
         src_mf_bits = 2'b00;
      end
      // Parity, fixed one, AIS, REI, OEI, multiframe pair
      next_n2 = {src_bip_prev, 1'b1, adapted_signal_fail_in, ei_frame, src_mf_bits};
      if (src_is_v5) begin
         next_src_byte = {src_s2[7:6] ^ src_comp, src_s2[5:0]};
      end else if (src_is_n2) begin
         next_src_byte = next_n2;
      end else begin
         next_src_byte = src_s2[7:0];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_pos <= LAST_POS;
         src_mf <= MF_LAST;
         src_data_out <= 8'h00;
         src_fs_out <= 1'b0;
      end else if (edge_seen) begin
         src_pos <= next_src_pos;
         src_data_out <= next_src_byte;
         src_fs_out <= src_s2[8];
         if (src_is_n2) begin
            src_mf <= next_src_mf;
         end
      end
   end

   // Parity runs over the altered container so a downstream monitor agrees
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_acc <= 2'b00;
         src_bip_prev <= 2'b00;
         src_comp <= 2'b00;
      end else if (edge_seen) begin
         if (src_is_v5) begin
            src_bip_prev <= src_acc;
            src_acc <= vto_fold(next_src_byte);
         end else begin
            src_acc <= src_acc ^ vto_fold(next_src_byte);
         end
         // V5 delta equals src_comp itself, so only the overhead delta is added
         if (src_is_n2) begin
            src_comp <= src_comp ^ vto_fold(src_s2[7:0] ^ next_n2);
         end
      end
   end

   // Error inputs are pulses: gather over a frame, send in the next one
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ei_acc <= 2'b00;
         ei_frame <= 2'b00;
      end else if (edge_seen && src_is_v5) begin
         ei_frame <= ei_acc | {remote_error_count_in, outgoing_error_count_in};
         ei_acc <= 2'b00;
      end else begin
         ei_acc <= ei_acc | {remote_error_count_in, outgoing_error_count_in};
      end
   end

   // ---------------- Sink ----------------
   logic [POS_W-1:0] snk_pos, next_snk_pos;
   logic [MF_W-1:0] snk_mf, next_snk_mf;
   logic [1:0] snk_acc, snk_bip_prev;
   logic [15:0] fas_shift, next_fas;
   logic fas_err;
   logic snk_is_v5, snk_is_n2;
   logic [TRACE_BITS-1:0] rx_shift, next_rx_shift, rx_last, accepted_trace_id;

   always_comb begin
      next_snk_pos = (snk_s2[8] || snk_pos == LAST_POS) ? '0 : snk_pos + 7'h01;
      snk_is_v5 = (next_snk_pos == '0);
      snk_is_n2 = (next_snk_pos == N2_AT);
      next_snk_mf = (snk_mf == MF_LAST) ? '0 : snk_mf + 7'h01;
      next_fas = {fas_shift[13:0], snk_s2[1:0]};
      next_rx_shift = {rx_shift[TRACE_BITS-3:0], snk_s2[1:0]};
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         snk_pos <= LAST_POS;
         snk_acc <= 2'b00;
         snk_bip_prev <= 2'b00;
      end else if (edge_seen) begin
         snk_pos <= next_snk_pos;
         if (snk_is_v5) begin
            snk_bip_prev <= snk_acc;
            snk_acc <= vto_fold(snk_s2[7:0]);
         end else begin
            snk_acc <= snk_acc ^ vto_fold(snk_s2[7:0]);
         end
      end
   end

   // Per-frame overhead extraction; pulses last one clk_in cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         near_errored_block_out <= 1'b0;
         far_errored_block_out <= 1'b0;
         outgoing_far_errored_block_out <= 1'b0;
         incoming_ais_out <= 1'b0;
      end else begin
         near_errored_block_out <= edge_seen && snk_is_n2 && (snk_s2[7:6] != snk_bip_prev);
         far_errored_block_out <= edge_seen && snk_is_n2 && snk_s2[3];
         outgoing_far_errored_block_out <= edge_seen && snk_is_n2 && snk_s2[2];
         if (edge_seen && snk_is_n2) begin
            incoming_ais_out <= snk_s2[4];
         end
      end
   end

   // Multiframe alignment, hunting while out of multiframe
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         snk_mf <= MF_LAST;
         fas_shift <= 16'h0000;
         fas_err <= 1'b0;
         in_multiframe_out <= 1'b0;
      end else if (edge_seen && snk_is_n2) begin
         fas_shift <= next_fas;
         if (!in_multiframe_out) begin
            if (next_fas == FAS_PATTERN) begin
               in_multiframe_out <= 1'b1;
               snk_mf <= MF_FAS_END;
               fas_err <= 1'b0;
            end else begin
               snk_mf <= next_snk_mf;
            end
         end else begin
            snk_mf <= next_snk_mf;
            if (next_snk_mf == MF_FAS_END) begin
               fas_err <= (next_fas != FAS_PATTERN);
               if (next_fas != FAS_PATTERN && fas_err) begin
                  in_multiframe_out <= 1'b0;
               end
            end
         end
      end
   end

   // Trace, RDI and ODI only trusted while aligned
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_shift <= '0;
         rx_last <= '0;
         accepted_trace_id <= '0;
         remote_defect_out <= 1'b0;
         outgoing_defect_out <= 1'b0;
      end else if (edge_seen && snk_is_n2 && in_multiframe_out) begin
         if (next_snk_mf >= MF_TRACE_FIRST && next_snk_mf <= MF_TRACE_LAST) begin
            rx_shift <= next_rx_shift;
         end
         // Single trace mode: accept after two identical multiframes
         if (next_snk_mf == MF_TRACE_LAST) begin
            rx_last <= next_rx_shift;
            if (next_rx_shift == rx_last) begin
               accepted_trace_id <= next_rx_shift;
            end
         end
         if (next_snk_mf == MF_RDI) begin
            remote_defect_out <= snk_s2[0];
         end
         if (next_snk_mf == MF_ODI) begin
            outgoing_defect_out <= snk_s2[1];
         end
      end
   end

   // ---------------- Register slave ----------------
   logic bus_ack;
   logic bus_req;
   logic [31:0] next_rdata;

   assign bus_req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = bus_req & ~bus_ack;

   always_comb begin
      case (avs_address_in)
         REG_TX_TRACE0: next_rdata = tx_trace[127:96];
         REG_TX_TRACE1: next_rdata = tx_trace[95:64];
         REG_TX_TRACE2: next_rdata = tx_trace[63:32];
         REG_TX_TRACE3: next_rdata = tx_trace[31:0];
         REG_ACC_TRACE0: next_rdata = accepted_trace_id[127:96];
         REG_ACC_TRACE1: next_rdata = accepted_trace_id[95:64];
         REG_ACC_TRACE2: next_rdata = accepted_trace_id[63:32];
         REG_ACC_TRACE3: next_rdata = accepted_trace_id[31:0];
         REG_STATUS: next_rdata = {28'h0000000, outgoing_defect_out, remote_defect_out,
                                   incoming_ais_out, in_multiframe_out};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // One wait cycle per access; unmapped reads return zero
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_ack <= 1'b0;
         avs_readdata_out <= 32'h00000000;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         if (avs_read_in && !bus_ack) begin
            avs_readdata_out <= next_rdata;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_trace <= TX_TRACE_RESET;
      end else if (avs_write_in && bus_ack && avs_address_in < REG_ACC_TRACE0) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_in[b]) begin
               tx_trace[(3 - int'(avs_address_in[3:2])) * 32 + b * 8 +: 8] <=
                  avs_writedata_in[b * 8 +: 8];
            end
         end
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_n2_fixed_one: assert property (edge_seen && src_is_n2 |=> src_data_out[5])
      else $error("overhead bit 3 not one");
   a_ais_follow: assert property (edge_seen && src_is_n2
         |=> src_data_out[4] == $past(adapted_signal_fail_in))
      else $error("overhead bit 4 does not follow signal fail");
   a_fas_ones: assert property (edge_seen && src_is_n2 && next_src_mf < MF_FAS_END
         |=> src_data_out[1:0] == 2'b11)
      else $error("alignment ones missing");
   a_fas_zero: assert property (edge_seen && src_is_n2 && next_src_mf == MF_FAS_END
         |=> src_data_out[1:0] == 2'b10)
      else $error("alignment closing zero missing");
   a_reserved_zero: assert property (edge_seen && src_is_n2 && next_src_mf > MF_ODI
         |=> src_data_out[1:0] == 2'b00)
      else $error("reserved multiframe bits not zero");
   a_parity_insert: assert property (edge_seen && src_is_n2
         |=> src_data_out[7:6] == $past(src_bip_prev))
      else $error("inserted parity differs from previous frame");
   a_counter_range: assert property (src_mf <= MF_LAST && snk_mf <= MF_LAST)
      else $error("multiframe counter out of range");
   a_parity_flag: assert property (edge_seen && snk_is_n2 && snk_s2[7:6] != snk_bip_prev
         |=> near_errored_block_out ##1 !near_errored_block_out)
      else $error("near errored block not flagged for one cycle");
   a_align_loss: assert property (edge_seen && snk_is_n2 && in_multiframe_out && fas_err
         && next_snk_mf == MF_FAS_END && next_fas != FAS_PATTERN |=> !in_multiframe_out)
      else $error("alignment not lost after two errored patterns");
   a_align_regain: assert property (edge_seen && snk_is_n2 && !in_multiframe_out
         && next_fas == FAS_PATTERN |=> in_multiframe_out && snk_mf == MF_FAS_END)
      else $error("alignment not regained");
   a_bus_answer: assert property (bus_req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("bus not answered in one cycle");
endmodule

// ==== vto_stream_model.sv ====
// Far-side model: link clock, source feed and sink loopback
`timescale 1ns/100ps
module vto_stream_model #(
   // Short frames keep one whole multiframe inside the run time
   parameter int FRAME_LEN = 56
) (
   // Error injection
   input wire logic flip_in,
   // Source output looped back
   input wire logic [7:0] loop_data_in,
   input wire logic loop_fs_in,
   // Link clock and source feed
   output logic link_clk_out,
   output logic [7:0] data_out,
   output logic fs_out,
   output logic [7:0] frame_out,
   // Sink feed
   output logic [7:0] snk_data_out,
   output logic snk_fs_out
);
   logic [7:0] pos = 8'(FRAME_LEN - 1);
   logic [7:0] acc = 8'h00;
   logic [7:0] lpos = 8'h00;
   initial begin
      link_clk_out = 1'b0;
      data_out = 8'h00;
      fs_out = 1'b0;
      frame_out = 8'h00;
      // Offset keeps link edges off the system clock edges
      #1.3;
      forever #62.5 link_clk_out = ~link_clk_out;
   end
   // Feed moves on the falling edge, far from the rising sample point
   always @(negedge link_clk_out) begin
      pos = (pos == 8'(FRAME_LEN - 1)) ? 8'h00 : pos + 8'h01;
      fs_out = (pos == 8'h00);
      if (fs_out) begin
         frame_out = frame_out + 8'h01;
         data_out = {^{acc[7], acc[5], acc[3], acc[1]}, ^{acc[6], acc[4], acc[2], acc[0]}, 6'h15};
         acc = data_out;
      end else begin
         data_out = pos * 8'h1d + frame_out;
         acc = acc ^ data_out;
      end
      lpos = loop_fs_in ? 8'h00 : lpos + 8'h01;
   end
   // A commanded flip of byte 10 spoils that frame's parity only
   assign snk_data_out = loop_data_in ^ ((flip_in && lpos == 8'h0a) ? 8'h10 : 8'h00);
   assign snk_fs_out = loop_fs_in;
endmodule

// ==== vto_tandem_term_tb.sv ====
// Self-checking bench for the tandem overhead termination block
`timescale 1ns/100ps
module vto_tandem_term_tb;
   import vto_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic sf = 1'b0, rei = 1'b0, oei = 1'b0, rdi = 1'b0, odi = 1'b0, flip = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_addr = 6'h00;
   logic [31:0] avs_wdata = 32'h0;
   logic [3:0] avs_be = 4'h0;
   logic [31:0] rdata, rd_data;
   logic link_clk, src_fs, src_fs_out, snk_fs, wreq, near, far, ofar, ais, rd, od, im;
   logic [7:0] src_data, src_data_out, snk_data, frame, opos, oacc, pacc;
   logic [255:0] rei_h = '0, oei_h = '0;
   logic exp_ais = 1'b0, exp_rd = 1'b0, exp_od = 1'b0;
   logic [127:0] tr = {32'h1234569a, 32'h0f1e2d3c, 32'h4b5a6978, 32'h8796a5b4};
   int fails = 0, n_tests = 0, cyc = 0, ofr = 0, n_near = 0, n_far = 0, n_ofar = 0;
   // Frame, then sf rei oei rdi odi flip, then the ais expected at that frame
   logic [14:0] rows [5] = '{{8'h02, 7'h40}, {8'h04, 7'h21}, {8'h05, 7'h30},
                             {8'h0c, 7'h02}, {8'h46, 7'h0c}};

   vto_tandem_term i_vto_tandem_term (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk),
      .src_data_in(src_data), .src_fs_in(src_fs), .src_data_out(src_data_out),
      .src_fs_out(src_fs_out), .adapted_signal_fail_in(sf), .remote_defect_request_in(rdi),
      .remote_error_count_in(rei), .outgoing_defect_request_in(odi),
      .outgoing_error_count_in(oei), .snk_data_in(snk_data), .snk_fs_in(snk_fs),
      .near_errored_block_out(near), .far_errored_block_out(far),
      .outgoing_far_errored_block_out(ofar), .incoming_ais_out(ais),
      .remote_defect_out(rd), .outgoing_defect_out(od), .in_multiframe_out(im),
      .avs_address_in(avs_addr), .avs_read_in(avs_read), .avs_write_in(avs_write),
      .avs_writedata_in(avs_wdata), .avs_byteenable_in(avs_be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq));

   vto_stream_model i_vto_stream_model (
      .flip_in(flip), .loop_data_in(src_data_out), .loop_fs_in(src_fs_out),
      .link_clk_out(link_clk), .data_out(src_data), .fs_out(src_fs), .frame_out(frame),
      .snk_data_out(snk_data), .snk_fs_out(snk_fs));

   initial begin
      forever #4 clk_in = ~clk_in;
   end

   function automatic logic [1:0] par2(input logic [7:0] b);
      return {^{b[7], b[5], b[3], b[1]}, ^{b[6], b[4], b[2], b[0]}};
   endfunction

   function automatic logic [1:0] mf_exp(input int k);
      int f;
      f = (k - 1) % 76 + 1;
      if (f <= 8) return FAS_PATTERN[17 - 2 * f -: 2];
      if (f <= 72) return tr[145 - 2 * f -: 2];
      if (f == 73) return {1'b0, rdi};
      if (f == 74) return {odi, 1'b0};
      return 2'h0;
   endfunction

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task close_out;
      if (fails == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Request held until the edge that sees waitrequest low
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_in);
      avs_write <= wr;
      avs_read <= !wr;
      avs_addr <= a;
      avs_wdata <= d;
      avs_be <= be;
      // Sampled on the rising edge itself; the answer is taken at that edge only
      @(posedge clk_in);
      while (wreq !== 1'b0) @(posedge clk_in);
      rd_data = rdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // Source stream monitor, sampled mid link period when outputs stand
   always @(negedge link_clk) begin
      if (src_fs_out === 1'b1) begin
         opos = 8'h00;
         ofr++;
         pacc = oacc;
         oacc = src_data_out;
         if (ofr >= 2) begin
            chk("v5 parity", par2(pacc), src_data_out[7:6]);
            chk("incoming ais", exp_ais, ais);
            chk("in multiframe", ofr >= 9, im);
            chk("remote defect", exp_rd, rd);
            chk("outgoing defect", exp_od, od);
         end
      end else begin
         opos++;
         oacc ^= src_data_out;
      end
      if (ofr >= 1 && opos == 8'h34) begin
         chk("n2 bits 3-6", {1'b1, sf, rei_h[ofr-1], oei_h[ofr-1]}, src_data_out[5:2]);
         if (ofr >= 2) chk("n2 parity", par2(pacc), src_data_out[7:6]);
         chk("n2 multiframe", mf_exp(ofr), src_data_out[1:0]);
         exp_ais = sf;
         if (ofr == 73) exp_rd = rdi;
         if (ofr == 74) exp_od = odi;
      end
   end

   // Pulse counts, skipping start-up frames with no valid history
   always @(negedge clk_in) begin
      if (ofr >= 3) begin
         n_near += (near === 1'b1);
         n_far += (far === 1'b1);
         n_ofar += (ofar === 1'b1);
      end
      cyc++;
      if (cyc > 80000) begin
         fails++;
         close_out;
      end
   end

   initial begin
      repeat (6) @(posedge clk_in);
      chk("reset outputs", 32'h0, {src_fs_out, near, far, ofar, ais, rd, od, im, wreq});
      rst_n_in <= 1'b1;
      bus(1'b1, REG_TX_TRACE0, 32'h12345678, 4'hf);
      // Word 0 rewritten with only its low byte enabled
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 6'(4 * i), tr[127 - 32 * i -: 32] ^ {{24{i == 0}}, 8'h00}, (i == 0) ? 4'h1 : 4'hf);
      end
      bus(1'b1, 6'h24, 32'hffffffff, 4'hf);
      bus(1'b1, REG_ACC_TRACE0, 32'hffffffff, 4'hf);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 6'(4 * i), 32'h0, 4'hf);
         chk("tx trace word", tr[127 - 32 * i -: 32], rd_data);
      end
      bus(1'b0, 6'h24, 32'h0, 4'hf);
      chk("unmapped read", 32'h0, rd_data);
      bus(1'b0, REG_ACC_TRACE0, 32'h0, 4'hf);
      chk("accepted trace read only", 32'h0, rd_data);
      foreach (rows[r]) begin
         while (frame !== rows[r][14:7]) @(posedge clk_in);
         chk("row ais", rows[r][0], ais);
         // Pulse only once the block has opened this frame, so it counts in it
         while (src_fs_out !== 1'b1) @(posedge clk_in);
         {sf, rei, oei, rdi, odi, flip} <= rows[r][6:1];
         rei_h[frame] = rows[r][5];
         oei_h[frame] = rows[r][4];
         @(posedge clk_in);
         rei <= 1'b0;
         oei <= 1'b0;
         while (rows[r][1] && frame === rows[r][14:7]) @(posedge clk_in);
         flip <= 1'b0;
      end
      while (ofr < 77) @(posedge clk_in);
      bus(1'b0, REG_STATUS, 32'h0, 4'hf);
      chk("status", 32'h0000000d, rd_data);
      chk("near errored count", 32'h1, n_near);
      chk("far errored count", 32'h2, n_far);
      chk("outgoing errored count", 32'h1, n_ofar);
      close_out;
   end
endmodule
